// ### alm_consts.svh
/*
 * Offsets, field positions, codes and timing counts of the alarm log.
 * Assumes nothing.
 */
`ifndef ALM_CONSTS_SVH
`define ALM_CONSTS_SVH

// register byte offsets
`define ALM_REG_TALLY 8'h00
`define ALM_REG_LATEST 8'h04
`define ALM_REG_STATUS 8'h08
`define ALM_REG_RT_MS 8'h0C
`define ALM_REG_RT_DAYS 8'h10
`define ALM_REG_FLT_CODE 8'h14
`define ALM_REG_FLT_VAL 8'h18
`define ALM_REG_IRQ_ST 8'h1C
`define ALM_REG_IRQ_MSK 8'h20
`define ALM_REG_SEL 8'h24
`define ALM_REG_E_CODE 8'h28
`define ALM_REG_E_FIX 8'h2C
`define ALM_REG_E_FLO 8'h30
`define ALM_REG_E_ADAYS 8'h34
`define ALM_REG_E_AMS 8'h38
`define ALM_REG_E_CDAYS 8'h3C
`define ALM_REG_E_CMS 8'h40
`define ALM_REG_E_FLAGS 8'h44
`define ALM_REG_RC_BASE 8'h80

// sizes
`define ALM_RC_SLOTS 20
`define ALM_BUF_SLOTS 8
`define ALM_LOG_DEPTH 64
`define ALM_HIST_SLOTS 56
`define ALM_HIST_BASE 6'h08

// status word bits
`define ALM_SW_FAULT_BIT 3
`define ALM_SW_ALARM_BIT 7

// message types
`define ALM_MT_FAULT 2'h1
`define ALM_MT_ALARM 2'h2
`define ALM_MT_NONE 2'h3

// interrupt status bits
`define ALM_IRQ_NEW 0
`define ALM_IRQ_GONE 1
`define ALM_IRQ_FAULT 2
`define ALM_IRQ_XFER 3
`define ALM_IRQ_W 4

// timing
`define ALM_CLK_NS 100
`define ALM_MS_NS 1000000
`define ALM_CYC_PER_MS (`ALM_MS_NS / `ALM_CLK_NS)
`define ALM_DAY_MS 86400000

`endif

// ### alm_log.sv
/*
 * Alarm log manager: buffer, history, tally, reclass and faults.
 * Assumes events are synchronous to sys_clk_i and held off while
 * busy_o is high; fault_ack_i may be asynchronous.
 */
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "alm_consts.svh"

//Function
// - tally counts every alarm logged since the tally was last reset.
// - writing zero to the tally moves removed buffer alarms to history.
// - arrival time in milliseconds of the day is stored per entry.
// - arrival time in whole days is stored per entry.
// - removal time, milliseconds and days, is stored when the cause goes.
// - each logged alarm's code is stored in its entry.
// - latest code register holds the most recent logged alarm's code; fault and suppressed raises leave it.
// - each entry stores the diagnostic value as fixed and float words.
// - twenty reclassification slots each hold one alarm number.
// - a slot's number selects the alarm whose message type changes.
// - type 1 raises a fault, 2 keeps an alarm, 3 suppresses.
// - a present fault sets status bit 3 and lights the red indicator.
// - fault clears only after cause gone and acknowledge given.
// - every fault exposes its code and value for diagnosis.
// - buffer holds eight; full with none removed overwrites next-to-last.
// - history youngest at index 8; oldest dropped once index 63 filled.
// - any pending alarm sets status bit 7.
// - runtime milliseconds wrap at 86,400,000 and bump the day count.
module alm_log
  import alm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `ALM_CYC_PER_MS,
  parameter int RC_SLOTS = `ALM_RC_SLOTS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // monitoring events
  input wire logic alarm_raise_i,
  input wire logic alarm_gone_i,
  input wire logic [15:0] alarm_code_i,
  input wire logic [31:0] alarm_fixed_i,
  input wire logic [31:0] alarm_float_i,
  input wire logic fault_ack_i,
  // status
  output logic busy_o,
  output logic [15:0] first_status_word_o,
  output logic [15:0] latest_alarm_code_o,
  output logic rdy_red_o,
  output logic irq_o
);

  localparam int NB = `ALM_BUF_SLOTS;
  localparam int NH = `ALM_HIST_SLOTS;

  alm_state_t st_r;
  logic [2:0] map_r [NB];
  logic [15:0] bcode_r [NB];
  logic [NB-1:0] vld_r, rmv_r;
  logic pend_r, xreq_r, ereq_r;
  alm_entry_t pend_e_r, snap_r;
  logic [2:0] xi_r;
  logic [5:0] head_r, hcnt_r, sel_r;
  logic [15:0] tally_r;
  logic [1:0] snap_f_r;
  logic flt_r, flt_gone_r;
  logic [15:0] flt_code_r;
  logic [31:0] flt_val_r;
  logic [`ALM_IRQ_W-1:0] ist_r, imsk_r, ev;
  logic ack_s1_r, ack_s2_r;
  logic [15:0] rc_num_r [RC_SLOTS];
  logic [1:0] rc_type_r [RC_SLOTS];
  logic [RC_SLOTS-1:0] rc_hit;
  logic [NB-1:0] gm;
  logic [31:0] rt_ms;
  logic [15:0] rt_days;

  alm_mem_if mif ();

  alm_rtc #(.CYC_PER_MS(CYC_PER_MS)) u_rtc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ms_o(rt_ms),
    .days_o(rt_days)
  );

  alm_mem #(.DEPTH(`ALM_LOG_DEPTH)) u_mem (
    .sys_clk_i(sys_clk_i),
    .port(mif.mem)
  );

  // register decode
  logic [4:0] rc_idx;
  logic rc_sel, wr_tally, wr_sel;
  assign rc_idx = reg_addr_i[6:2];
  assign rc_sel = reg_addr_i[7] && (rc_idx < 5'(RC_SLOTS));
  assign wr_tally = reg_wr_i && (reg_addr_i == `ALM_REG_TALLY);
  assign wr_sel = reg_wr_i && (reg_addr_i == `ALM_REG_SEL);

  // reclassification slots
  for (genvar k = 0; k < RC_SLOTS; k++) begin : g_rc
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rc_num_r[k] <= '0;
        rc_type_r[k] <= `ALM_MT_ALARM;
      end else if (reg_wr_i && rc_sel && rc_idx == 5'(k)) begin
        rc_num_r[k] <= reg_wdata_i[15:0];
        rc_type_r[k] <= reg_wdata_i[17:16];
      end
    end
    assign rc_hit[k] = (rc_num_r[k] == alarm_code_i);
  end

  for (genvar j = 0; j < NB; j++) begin : g_gm
    assign gm[j] = vld_r[j] && !rmv_r[j] && bcode_r[j] == alarm_code_i;
  end

  // lowest matching slot decides; type 0 is ignored
  logic [1:0] kind;
  always_comb begin
    kind = `ALM_MT_ALARM;
    for (int k = RC_SLOTS - 1; k >= 0; k--) begin
      if (rc_hit[k] && rc_type_r[k] != 2'h0) begin
        kind = rc_type_r[k];
      end
    end
  end

  logic [2:0] gsel, ins_i;
  always_comb begin
    gsel = '0;
    ins_i = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (gm[i]) gsel = 3'(i);
      if (!vld_r[i]) ins_i = 3'(i);
    end
  end

  logic take_raise, take_gone, gone_hit, full, any_rmv, do_ins;
  assign take_raise = alarm_raise_i && !busy_o;
  assign take_gone = alarm_gone_i && !busy_o;
  assign gone_hit = take_gone && (|gm);
  assign full = &vld_r;
  assign any_rmv = |(vld_r & rmv_r);
  assign do_ins = st_r == ST_IDLE && pend_r && !(full && any_rmv);

  // compaction: kept alarms first in order, freed slots after
  logic [2:0] c_map [NB];
  logic [15:0] c_code [NB];
  logic [NB-1:0] c_vld;
  logic [3:0] c_n;
  always_comb begin
    c_n = '0;
    c_vld = '0;
    for (int i = 0; i < NB; i++) begin
      c_map[i] = map_r[i];
      c_code[i] = bcode_r[i];
    end
    for (int i = 0; i < NB; i++) begin
      if (vld_r[i] && !rmv_r[i]) begin
        c_map[c_n[2:0]] = map_r[i];
        c_code[c_n[2:0]] = bcode_r[i];
        c_vld[c_n[2:0]] = 1'b1;
        c_n = c_n + 4'h1;
      end
    end
    for (int i = 0; i < NB; i++) begin
      if (!(vld_r[i] && !rmv_r[i])) begin
        c_map[c_n[2:0]] = map_r[i];
        c_n = c_n + 4'h1;
      end
    end
  end

  // history index 8+k maps onto a ring, youngest just below head
  logic [6:0] rpos;
  logic [5:0] phys_sel;
  logic sel_ok;
  always_comb begin
    rpos = {1'b0, head_r} + 7'(NH - 1) - {1'b0, sel_r - `ALM_HIST_BASE};
    if (rpos >= 7'(NH)) rpos = rpos - 7'(NH);
    if (sel_r < `ALM_HIST_BASE) begin
      phys_sel = {3'h0, map_r[sel_r[2:0]]};
      sel_ok = vld_r[sel_r[2:0]];
    end else begin
      phys_sel = `ALM_HIST_BASE + rpos[5:0];
      sel_ok = (sel_r - `ALM_HIST_BASE) < hcnt_r;
    end
  end

  // memory port
  always_comb begin
    mif.we_full = 1'b0;
    mif.we_clr = 1'b0;
    mif.waddr = '0;
    mif.wdata = pend_e_r;
    if (do_ins) begin
      mif.we_full = 1'b1;
      mif.waddr = {3'h0, full ? map_r[NB-2] : map_r[ins_i]};
    end else if (st_r == ST_XWR) begin
      mif.we_full = 1'b1;
      mif.waddr = `ALM_HIST_BASE + head_r;
      mif.wdata = mif.rdata;
    end else if (gone_hit) begin
      mif.we_clr = 1'b1;
      mif.waddr = {3'h0, map_r[gsel]};
      mif.wdata.clr_ms = rt_ms;
      mif.wdata.clr_days = rt_days;
    end
    mif.raddr = (st_r == ST_XRD) ? {3'h0, map_r[xi_r]} : phys_sel;
  end

  // sequencer and buffer bookkeeping
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      vld_r <= '0;
      rmv_r <= '0;
      pend_r <= 1'b0;
      xreq_r <= 1'b0;
      ereq_r <= 1'b0;
      busy_o <= 1'b0;
      xi_r <= '0;
      head_r <= '0;
      hcnt_r <= '0;
      for (int i = 0; i < NB; i++) begin
        map_r[i] <= 3'(i);
        bcode_r[i] <= '0;
      end
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          busy_o <= 1'b0;
          if (do_ins) begin
            pend_r <= 1'b0;
            if (full) begin
              map_r[NB-2] <= map_r[NB-1];
              map_r[NB-1] <= map_r[NB-2];
              bcode_r[NB-2] <= bcode_r[NB-1];
              bcode_r[NB-1] <= pend_e_r.code;
            end else begin
              vld_r[ins_i] <= 1'b1;
              rmv_r[ins_i] <= 1'b0;
              bcode_r[ins_i] <= pend_e_r.code;
            end
          end else if (xreq_r || pend_r) begin
            xi_r <= '0;
            busy_o <= 1'b1;
            st_r <= ST_XRD;
          end else if (ereq_r) begin
            ereq_r <= 1'b0;
            busy_o <= 1'b1;
            st_r <= ST_ERD;
          end
        end
        ST_XRD: begin
          if (vld_r[xi_r] && rmv_r[xi_r]) begin
            st_r <= ST_XWR;
          end else if (xi_r == 3'(NB - 1)) begin
            st_r <= ST_CMP;
          end else begin
            xi_r <= xi_r + 3'h1;
          end
        end
        ST_XWR: begin
          head_r <= (head_r == 6'(NH - 1)) ? '0 : head_r + 6'h01;
          if (hcnt_r < 6'(NH)) hcnt_r <= hcnt_r + 6'h01;
          xi_r <= xi_r + 3'h1;
          st_r <= (xi_r == 3'(NB - 1)) ? ST_CMP : ST_XRD;
        end
        ST_CMP: begin
          map_r <= c_map;
          bcode_r <= c_code;
          vld_r <= c_vld;
          rmv_r <= '0;
          xreq_r <= 1'b0;
          busy_o <= pend_r;
          st_r <= ST_IDLE;
        end
        ST_ERD: st_r <= ST_ECAP;
        ST_ECAP: begin
          busy_o <= 1'b0;
          st_r <= ST_IDLE;
        end
      endcase
      if (wr_tally && reg_wdata_i == '0) xreq_r <= 1'b1;
      if (wr_sel) ereq_r <= 1'b1;
      if (gone_hit) rmv_r[gsel] <= 1'b1;
      if (take_raise && kind == `ALM_MT_ALARM) begin
        pend_r <= 1'b1;
        busy_o <= 1'b1;
      end
    end
  end

  // pending entry, time stamped when taken
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_e_r <= '0;
    end else if (take_raise && kind == `ALM_MT_ALARM) begin
      pend_e_r.code <= alarm_code_i;
      pend_e_r.fixv <= alarm_fixed_i;
      pend_e_r.flov <= alarm_float_i;
      pend_e_r.arr_ms <= rt_ms;
      pend_e_r.arr_days <= rt_days;
      pend_e_r.clr_ms <= '0;
      pend_e_r.clr_days <= '0;
    end
  end

  // tally and latest code
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tally_r <= '0;
      latest_alarm_code_o <= '0;
    end else begin
      if (wr_tally) tally_r <= reg_wdata_i[15:0];
      else if (do_ins) tally_r <= tally_r + 16'h0001;
      if (take_raise && kind == `ALM_MT_ALARM) begin
        latest_alarm_code_o <= alarm_code_i;
      end
    end
  end

  // entry snapshot for software
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snap_r <= '0;
      snap_f_r <= '0;
      sel_r <= '0;
    end else begin
      if (wr_sel) sel_r <= reg_wdata_i[5:0];
      if (st_r == ST_ECAP) begin
        snap_r <= sel_ok ? mif.rdata : '0;
        snap_f_r <= {sel_ok && (sel_r >= `ALM_HIST_BASE ||
                     rmv_r[sel_r[2:0]]), sel_ok};
      end
    end
  end

  // acknowledge synchroniser
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= fault_ack_i;
      ack_s2_r <= ack_s1_r;
    end
  end

  // fault flag
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flt_r <= 1'b0;
      flt_gone_r <= 1'b0;
      flt_code_r <= '0;
      flt_val_r <= '0;
    end else if (take_raise && kind == `ALM_MT_FAULT) begin
      flt_r <= 1'b1;
      flt_gone_r <= 1'b0;
      flt_code_r <= alarm_code_i;
      flt_val_r <= alarm_fixed_i;
    end else begin
      if (flt_r && take_gone && alarm_code_i == flt_code_r) begin
        flt_gone_r <= 1'b1;
      end
      if (flt_r && flt_gone_r && ack_s2_r) begin
        flt_r <= 1'b0;
        flt_gone_r <= 1'b0;
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_comb begin
    ev = '0;
    ev[`ALM_IRQ_NEW] = do_ins;
    ev[`ALM_IRQ_GONE] = gone_hit;
    ev[`ALM_IRQ_FAULT] = take_raise && kind == `ALM_MT_FAULT;
    ev[`ALM_IRQ_XFER] = st_r == ST_CMP;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ist_r <= '0;
      imsk_r <= '0;
      irq_o <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `ALM_REG_IRQ_ST) begin
        ist_r <= (ist_r & ~reg_wdata_i[`ALM_IRQ_W-1:0]) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
      if (reg_wr_i && reg_addr_i == `ALM_REG_IRQ_MSK) begin
        imsk_r <= reg_wdata_i[`ALM_IRQ_W-1:0];
      end
      irq_o <= |(ist_r & imsk_r);
    end
  end

  // status word and indicator
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_status_word_o <= '0;
      rdy_red_o <= 1'b0;
    end else begin
      first_status_word_o <= '0;
      first_status_word_o[`ALM_SW_FAULT_BIT] <= flt_r;
      first_status_word_o[`ALM_SW_ALARM_BIT] <= |(vld_r & ~rmv_r);
      rdy_red_o <= flt_r;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_addr_i)
        `ALM_REG_TALLY: reg_rdata_o <= {16'h0000, tally_r};
        `ALM_REG_LATEST: reg_rdata_o <= {16'h0000, latest_alarm_code_o};
        `ALM_REG_STATUS: reg_rdata_o <= {16'h0000, first_status_word_o};
        `ALM_REG_RT_MS: reg_rdata_o <= rt_ms;
        `ALM_REG_RT_DAYS: reg_rdata_o <= {16'h0000, rt_days};
        `ALM_REG_FLT_CODE: reg_rdata_o <= {16'h0000, flt_code_r};
        `ALM_REG_FLT_VAL: reg_rdata_o <= flt_val_r;
        `ALM_REG_IRQ_ST: reg_rdata_o <= 32'(ist_r);
        `ALM_REG_IRQ_MSK: reg_rdata_o <= 32'(imsk_r);
        `ALM_REG_SEL: reg_rdata_o <= {26'h0, sel_r};
        `ALM_REG_E_CODE: reg_rdata_o <= {16'h0000, snap_r.code};
        `ALM_REG_E_FIX: reg_rdata_o <= snap_r.fixv;
        `ALM_REG_E_FLO: reg_rdata_o <= snap_r.flov;
        `ALM_REG_E_ADAYS: reg_rdata_o <= {16'h0000, snap_r.arr_days};
        `ALM_REG_E_AMS: reg_rdata_o <= snap_r.arr_ms;
        `ALM_REG_E_CDAYS: reg_rdata_o <= {16'h0000, snap_r.clr_days};
        `ALM_REG_E_CMS: reg_rdata_o <= snap_r.clr_ms;
        `ALM_REG_E_FLAGS: reg_rdata_o <= {29'h0, ereq_r ||
          st_r == ST_ERD || st_r == ST_ECAP, snap_f_r};
        default: reg_rdata_o <= rc_sel ? {14'h0, rc_type_r[rc_idx],
          rc_num_r[rc_idx]} : '0;
      endcase
    end
  end

endmodule : alm_log

// ### alm_log_bench.sv
/* Bench of the alarm log manager.
   Assumes the checker is bound to alm_log. */
`timescale 1ns/1ps
`include "alm_consts.svh"

module alm_log_bench;
  logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, busy_o, rdy_red_o, irq_o;
  logic alarm_raise_i, alarm_gone_i, fault_ack_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, alarm_fixed_i, alarm_float_i;
  logic [15:0] alarm_code_i, first_status_word_o, latest_alarm_code_o;
  logic [31:0] v, t0, t1;
  int mismatches, comparisons, cycles;

  alm_log #(.CYC_PER_MS(4)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .alarm_raise_i(alarm_raise_i),
    .alarm_gone_i(alarm_gone_i), .alarm_code_i(alarm_code_i),
    .alarm_fixed_i(alarm_fixed_i), .alarm_float_i(alarm_float_i),
    .fault_ack_i(fault_ack_i), .busy_o(busy_o),
    .first_status_word_o(first_status_word_o),
    .latest_alarm_code_o(latest_alarm_code_o), .rdy_red_o(rdy_red_o),
    .irq_o(irq_o));
  alm_mon_model u_mon (
    .sys_clk_i(sys_clk_i), .busy_i(busy_o), .raise_o(alarm_raise_i),
    .gone_o(alarm_gone_i), .code_o(alarm_code_i), .fixed_o(alarm_fixed_i),
    .float_o(alarm_float_i), .ack_o(fault_ack_i));

  always #50 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic results;
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rc

  task automatic sel(input logic [5:0] idx);
    wr(`ALM_REG_SEL, {26'h0, idx});
    repeat (6) @(posedge sys_clk_i);
  endtask : sel

  task automatic settle;
    int n;
    n = 0;
    repeat (3) @(negedge sys_clk_i);
    while (busy_o !== 1'b0 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 40) chk(32'h0000_0001, 32'h0000_0000);
    repeat (2) @(negedge sys_clk_i);
  endtask : settle

  task automatic raise(input logic [15:0] c);
    u_mon.post(1'b1, 1'b0, c);
    settle();
  endtask : raise

  task automatic gone(input logic [15:0] c);
    u_mon.post(1'b0, 1'b1, c);
    settle();
  endtask : gone

  task automatic ack_pulse;
    u_mon.ack(1'b1);
    repeat (8) @(posedge sys_clk_i);
    u_mon.ack(1'b0);
    repeat (4) @(negedge sys_clk_i);
  endtask : ack_pulse

  initial begin
    sys_clk_i = 1'b0;
    rst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i} = 2'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    {mismatches, comparisons, cycles} = '0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rc(`ALM_REG_TALLY, 32'h0000_0000);
    rc(`ALM_REG_LATEST, 32'h0000_0000);
    rc(`ALM_REG_STATUS, 32'h0000_0000);
    rc(`ALM_REG_RC_BASE, 32'h0002_0000);
    rc(8'h7C, 32'h0000_0000);
    wr(`ALM_REG_IRQ_MSK, 32'h0000_000F);
    wr(`ALM_REG_RC_BASE, 32'h0001_0101);
    wr(`ALM_REG_RC_BASE + 8'h04, 32'h0003_0202);
    wr(`ALM_REG_RC_BASE + 8'h4C, 32'h0002_0303);
    rc(`ALM_REG_RC_BASE + 8'h4C, 32'h0002_0303);
    rd(`ALM_REG_RT_MS, t0);
    raise(16'h0010);
    rd(`ALM_REG_RT_MS, t1);
    chk(32'(t1 > t0), 32'h0000_0001);
    chk({16'h0000, latest_alarm_code_o}, 32'h0000_0010);
    rc(`ALM_REG_TALLY, 32'h0000_0001);
    rc(`ALM_REG_STATUS, 32'h0000_0080);
    chk({31'h0, irq_o}, 32'h0000_0001);
    sel(6'h00);
    rc(`ALM_REG_E_CODE, 32'h0000_0010);
    rc(`ALM_REG_E_FIX, 32'h0000_0010);
    rc(`ALM_REG_E_FLO, 32'h0010_0000);
    rc(`ALM_REG_E_ADAYS, 32'h0000_0000);
    rd(`ALM_REG_E_AMS, v);
    chk(32'(v >= t0 && v <= t1), 32'h0000_0001);
    raise(16'h0202);
    rc(`ALM_REG_TALLY, 32'h0000_0001);
    raise(16'h0303);
    rc(`ALM_REG_TALLY, 32'h0000_0002);
    rc(`ALM_REG_LATEST, 32'h0000_0303);
    raise(16'h0101);
    rc(`ALM_REG_STATUS, 32'h0000_0088);
    chk({31'h0, rdy_red_o}, 32'h0000_0001);
    rc(`ALM_REG_FLT_CODE, 32'h0000_0101);
    rc(`ALM_REG_FLT_VAL, 32'h0000_0101);
    rc(`ALM_REG_TALLY, 32'h0000_0002);
    ack_pulse();
    chk({31'h0, rdy_red_o}, 32'h0000_0001);
    gone(16'h0101);
    ack_pulse();
    chk({31'h0, rdy_red_o}, 32'h0000_0000);
    rc(`ALM_REG_IRQ_ST, 32'h0000_0005);
    wr(`ALM_REG_IRQ_ST, 32'h0000_000F);
    rc(`ALM_REG_IRQ_ST, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wr(`ALM_REG_IRQ_MSK, 32'h0000_0000);
    gone(16'h0010);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rc(`ALM_REG_IRQ_ST, 32'h0000_0002);
    rc(`ALM_REG_STATUS, 32'h0000_0080);
    sel(6'h00);
    rc(`ALM_REG_E_FLAGS, 32'h0000_0003);
    rc(`ALM_REG_E_CDAYS, 32'h0000_0000);
    rd(`ALM_REG_E_CMS, v);
    chk(32'(v >= t1), 32'h0000_0001);
    wr(`ALM_REG_IRQ_MSK, 32'h0000_000F);
    wr(`ALM_REG_IRQ_ST, 32'h0000_000F);
    wr(`ALM_REG_TALLY, 32'h0000_0000);
    settle();
    rc(`ALM_REG_TALLY, 32'h0000_0000);
    rc(`ALM_REG_IRQ_ST, 32'h0000_0008);
    sel(6'h08);
    rc(`ALM_REG_E_CODE, 32'h0000_0010);
    sel(6'h00);
    rc(`ALM_REG_E_CODE, 32'h0000_0303);
    sel(6'h01);
    rc(`ALM_REG_E_FLAGS, 32'h0000_0000);
    for (int i = 1; i < 8; i++) raise(16'h0A00 + 16'(i));
    raise(16'h0AFF);
    rc(`ALM_REG_TALLY, 32'h0000_0008);
    sel(6'h07);
    rc(`ALM_REG_E_CODE, 32'h0000_0AFF);
    sel(6'h06);
    rc(`ALM_REG_E_CODE, 32'h0000_0A07);
    sel(6'h05);
    rc(`ALM_REG_E_CODE, 32'h0000_0A05);
    results();
  end
endmodule : alm_log_bench

// ### alm_log_sva.sv
/* Checker of the alarm log manager on its top ports.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps

module alm_log_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // watched inputs
  input wire logic alarm_raise_i,
  input wire logic alarm_gone_i,
  input wire logic [15:0] alarm_code_i,
  input wire logic fault_ack_i,
  // watched outputs
  input wire logic busy_o,
  input wire logic [15:0] first_status_word_o,
  input wire logic [15:0] latest_alarm_code_o,
  input wire logic rdy_red_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [4:0] busy_len_r;
  logic [3:0] ack_age_r, raise_age_r, gone_age_r;

  // saturating ages; the raise age holds while the sequencer is busy
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_len_r <= 5'h00;
      {ack_age_r, raise_age_r, gone_age_r} <= 12'hFFF;
    end else begin
      if (!busy_o) busy_len_r <= 5'h00;
      else if (busy_len_r != 5'h1F) busy_len_r <= busy_len_r + 5'h01;
      if (fault_ack_i) ack_age_r <= 4'h0;
      else if (ack_age_r != 4'hF) ack_age_r <= ack_age_r + 4'h1;
      if (alarm_raise_i && !busy_o) raise_age_r <= 4'h0;
      else if (raise_age_r != 4'hF && !busy_o)
        raise_age_r <= raise_age_r + 4'h1;
      if (alarm_gone_i && !busy_o) gone_age_r <= 4'h0;
      else if (gone_age_r != 4'hF) gone_age_r <= gone_age_r + 4'h1;
    end
  end

  a_red_status_match: assert property (
    rdy_red_o == first_status_word_o[3])
    else $error("red indicator differs from fault bit");
  a_status_spare_zero: assert property (
    (first_status_word_o & 16'hFF77) == 16'h0000)
    else $error("spare status bits set");
  a_latest_from_raise: assert property (
    $changed(latest_alarm_code_o) |->
      $past(alarm_raise_i && !busy_o) &&
      latest_alarm_code_o == $past(alarm_code_i))
    else $error("latest code without raise");
  a_red_after_raise: assert property (
    $rose(rdy_red_o) |-> $past(alarm_raise_i && !busy_o, 2))
    else $error("fault shown without raise");
  a_red_clear_ack: assert property (
    $fell(rdy_red_o) |-> ack_age_r <= 4'h6)
    else $error("fault cleared without ack");
  a_pending_after_raise: assert property (
    $rose(first_status_word_o[7]) |-> raise_age_r <= 4'h4)
    else $error("pending rose without raise");
  a_pending_drop_gone: assert property (
    $fell(first_status_word_o[7]) |-> gone_age_r <= 4'h4)
    else $error("pending fell without gone");
  a_busy_bounded: assert property (
    busy_len_r <= 5'h1A)
    else $error("busy too long");
endmodule : alm_log_sva

bind alm_log alm_log_sva u_sva (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .alarm_raise_i(alarm_raise_i), .alarm_gone_i(alarm_gone_i),
  .alarm_code_i(alarm_code_i), .fault_ack_i(fault_ack_i),
  .busy_o(busy_o), .first_status_word_o(first_status_word_o),
  .latest_alarm_code_o(latest_alarm_code_o), .rdy_red_o(rdy_red_o)
);

// ### alm_mem.sv
/*
 * Entry memory of the alarm log: buffer slots and history slots.
 * Assumes the sequencer never writes and reads the same word in
 * the same cycle when it needs the new value.
 */
`timescale 1ns/1ps

module alm_mem
  import alm_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input wire logic sys_clk_i,
  alm_mem_if.mem port
);

  alm_entry_t mem_r [DEPTH];

  // clear write touches only the removal time fields
  always_ff @(posedge sys_clk_i) begin
    if (port.we_full) begin
      mem_r[port.waddr] <= port.wdata;
    end else if (port.we_clr) begin
      mem_r[port.waddr].clr_days <= port.wdata.clr_days;
      mem_r[port.waddr].clr_ms <= port.wdata.clr_ms;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    port.rdata <= mem_r[port.raddr];
  end

endmodule : alm_mem

// ### alm_mem_if.sv
/*
 * Port between the log sequencer and the entry memory.
 * Assumes one write and one registered read per clock.
 */
`timescale 1ns/1ps

interface alm_mem_if;
  import alm_pkg::*;
  logic we_full;
  logic we_clr;
  logic [5:0] waddr;
  alm_entry_t wdata;
  logic [5:0] raddr;
  alm_entry_t rdata;

  modport ctl (output we_full, we_clr, waddr, wdata, raddr, input rdata);
  modport mem (input we_full, we_clr, waddr, wdata, raddr, output rdata);
endinterface : alm_mem_if

// ### alm_mon_model.sv
/* Monitoring side: event pulses and the acknowledge level.
   Assumes one call at a time. */
`timescale 1ns/1ps

module alm_mon_model (
  // clock and handshake
  input wire logic sys_clk_i,
  input wire logic busy_i,
  // events
  output logic raise_o,
  output logic gone_o,
  output logic [15:0] code_o,
  output logic [31:0] fixed_o,
  output logic [31:0] float_o,
  output logic ack_o
);
  initial begin
    {raise_o, gone_o, ack_o} = 3'h0;
    {code_o, fixed_o, float_o} = '0;
  end

  task automatic post(input logic r, input logic g, input logic [15:0] c);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (busy_i !== 1'b0 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
    raise_o <= r;
    gone_o <= g;
    code_o <= c;
    fixed_o <= {16'h0000, c};
    float_o <= {c, 16'h0000};
    @(posedge sys_clk_i);
    {raise_o, gone_o} <= 2'h0;
    // junk outside the pulse
    {code_o, fixed_o, float_o} <= ~{code_o, fixed_o, float_o};
  endtask : post

  task automatic ack(input logic a);
    @(posedge sys_clk_i);
    ack_o <= a;
  endtask : ack
endmodule : alm_mon_model

// ### alm_pkg.sv
/*
 * Types of the alarm log manager: log entry and sequencer states.
 * Assumes nothing.
 */
package alm_pkg;

  typedef struct packed {
    logic [15:0] code;
    logic [31:0] fixv;
    logic [31:0] flov;
    logic [15:0] arr_days;
    logic [31:0] arr_ms;
    logic [15:0] clr_days;
    logic [31:0] clr_ms;
  } alm_entry_t;

  typedef enum {
    ST_IDLE,
    ST_XRD,
    ST_XWR,
    ST_CMP,
    ST_ERD,
    ST_ECAP
  } alm_state_t;

endpackage : alm_pkg

// ### alm_rtc.sv
/*
 * System runtime counter: milliseconds within the day and days.
 * Assumes sys_clk_i runs continuously from power-on.
 */
`timescale 1ns/1ps
`include "alm_consts.svh"

module alm_rtc #(
  parameter int unsigned CYC_PER_MS = `ALM_CYC_PER_MS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // runtime
  output logic [31:0] ms_o,
  output logic [15:0] days_o
);

  logic [31:0] pre_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_r <= '0;
      ms_o <= '0;
      days_o <= '0;
    end else if (pre_r == 32'(CYC_PER_MS - 1)) begin
      pre_r <= '0;
      if (ms_o == 32'(`ALM_DAY_MS - 1)) begin
        ms_o <= '0;
        days_o <= days_o + 16'h0001;
      end else begin
        ms_o <= ms_o + 32'h0000_0001;
      end
    end else begin
      pre_r <= pre_r + 32'h0000_0001;
    end
  end

endmodule : alm_rtc
